// *** dv/tb_top.sv ***
// self-checking bench for the result, setup and limit registers
// assumes the link host model drives the link port; adc_code comes from here
`timescale 1ns/10ps
module tb_top;
   logic clock = 1'b0;
   logic link_clock = 1'b0;
   logic arst_n = 1'b0;
   logic [11:0] adc_code = 12'h000;
   logic pointer_load, pointer_high_bit, pointer_low_bit, data_write;
   logic [15:0] write_data, read_data, ambient_temperature;
   logic conv_start, converting;
   logic [7:0] sensor_setup;
   logic [8:0] lower_release_limit, upper_trip_limit;
   logic [2:0] fault_queue_count;
   int error_cnt = 0;
   int n_tests = 0;
   // ***************************************************
   // clocks and instances
   // ***************************************************
   always #5 clock = ~clock;
   always #62.5 link_clock = ~link_clock;
   // short base count keeps the 12-bit run at 160 cycles
   tsr_top #(.CONV9_CYCLES(25'h14)) tsr_top_i (.clock(clock), .arst_n(arst_n), .link_clock(link_clock),
      .pointer_load(pointer_load), .pointer_high_bit(pointer_high_bit), .pointer_low_bit(pointer_low_bit),
      .data_write(data_write), .write_data(write_data), .read_data(read_data), .adc_code(adc_code),
      .conv_start(conv_start), .converting(converting), .ambient_temperature(ambient_temperature),
      .sensor_setup(sensor_setup), .lower_release_limit(lower_release_limit),
      .upper_trip_limit(upper_trip_limit), .fault_queue_count(fault_queue_count));
   tsr_link_host tsr_link_host_i (.link_clock(link_clock), .read_data(read_data), .pointer_load(pointer_load),
      .pointer_high_bit(pointer_high_bit), .pointer_low_bit(pointer_low_bit), .data_write(data_write),
      .write_data(write_data));
   // ***************************************************
   // shared tasks
   // ***************************************************
   task automatic end_sim();
      if (error_cnt == 0 && n_tests > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
      n_tests++;
      if (got !== exp) begin
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
         error_cnt++;
      end
   endtask
   task automatic chk_rd(input logic [1:0] p, input logic [15:0] exp);
      logic [15:0] d;
      // the image crossing can lag a register change by about six link cycles
      repeat (4) @(posedge link_clock);
      tsr_link_host_i.rd(p, d);
      chk("read_data", exp, d);
   endtask
   // waits for a start, then counts cycles until the result moves
   task automatic meas(input int r, input logic [11:0] code, input logic [15:0] exp);
      int n;
      logic [15:0] old;
      n = 0;
      while (conv_start !== 1'b1) begin
         @(posedge clock);
         #1;
         n++;
         if (n > 5000) begin
            chk("conv_start", 16'h0001, 16'h0000);
            end_sim();
         end
      end
      // new code after the start, so the result differs from the one just loaded
      adc_code = code;
      old = ambient_temperature;
      n = 0;
      while (ambient_temperature === old && n < 5000) begin
         @(posedge clock);
         #1;
         n++;
      end
      chk("conversion cycles", 16'((20 << r) + 2), 16'(n));
      chk("ambient_temperature", exp, ambient_temperature);
   endtask
   // ***************************************************
   // scenarios
   // ***************************************************
   task automatic sc_reset();
      chk("sensor_setup", 16'h0000, {8'h00, sensor_setup});
      chk("fault_queue_count", 16'h0001, {13'h0, fault_queue_count});
      chk_rd(2'h2, 16'h4b00);
      chk_rd(2'h3, 16'h5000);
   endtask
   task automatic sc_setup();
      logic [2:0] fq_exp [4] = '{3'h1, 3'h2, 3'h4, 3'h6};
      tsr_link_host_i.wr(2'h1, 16'hab07);
      chk_rd(2'h1, 16'h0007);
      chk("converting", 16'h0000, {15'h0, converting});
      for (int q = 0; q < 4; q++) begin
         tsr_link_host_i.wr(2'h1, {8'h00, 3'h0, 2'(q), 3'h1});
         chk("fault_queue_count", {13'h0, fq_exp[q]}, {13'h0, fault_queue_count});
      end
   endtask
   task automatic sc_limits();
      tsr_link_host_i.wr(2'h3, 16'hffff);
      tsr_link_host_i.wr(2'h2, 16'h807f);
      chk_rd(2'h3, 16'hff80);
      chk_rd(2'h2, 16'h8000);
      chk("upper_trip_limit", 16'h01ff, {7'h0, upper_trip_limit});
      chk("lower_release_limit", 16'h0100, {7'h0, lower_release_limit});
   endtask
   // single runs at every resolution, each code chosen so the result moves
   task automatic sc_single();
      logic [11:0] codes [4] = '{12'hc35, 12'h19b, 12'h8f1, 12'h7ff};
      for (int r = 0; r < 4; r++) begin
         fork
            tsr_link_host_i.wr(2'h1, {8'h00, 1'b1, 2'(r), 5'h01});
            meas(r, codes[r], {codes[r], 4'h0} & ~(16'h007f >> r));
         join
         chk_rd(2'h1, {8'h00, 1'b0, 2'(r), 5'h01});
         chk_rd(2'h0, {codes[r], 4'h0} & ~(16'h007f >> r));
      end
   endtask
   // continuous 12-bit run: reads mid-run keep the last completed value
   task automatic sc_continuous();
      fork
         tsr_link_host_i.wr(2'h1, 16'h0060);
         meas(3, 12'h5a5, 16'h5a50);
      join
      adc_code = 12'h321;
      chk_rd(2'h0, 16'h5a50);
      meas(3, 12'h9c7, 16'h9c70);
      tsr_link_host_i.wr(2'h1, 16'h0001);
      repeat (200) @(posedge clock);
      #1;
      chk("converting", 16'h0000, {15'h0, converting});
      tsr_link_host_i.wr(2'h0, 16'h1234);
      chk_rd(2'h0, 16'h9c70);
      chk("ambient_temperature", 16'h9c70, ambient_temperature);
   endtask
   // ***************************************************
   // main sequence
   // ***************************************************
   initial begin
      repeat (3) @(posedge link_clock);
      #1;
      arst_n = 1'b1;
      repeat (4) @(posedge link_clock);
      sc_reset();
      sc_setup();
      sc_limits();
      sc_single();
      sc_continuous();
      end_sim();
   end
endmodule

// *** dv/tsr_link_host.sv ***
// link-side host model: pointer loads, register writes and reads on link_clock
// assumes link_clock runs free and read_data is registered on link_clock
`timescale 1ns/10ps
module tsr_link_host (
   input wire logic link_clock,
   input wire logic [15:0] read_data,
   output logic pointer_load,
   output logic pointer_high_bit,
   output logic pointer_low_bit,
   output logic data_write,
   output logic [15:0] write_data
);
   // ***************************************************
   // link requests
   // ***************************************************
   initial begin
      pointer_load = 1'b0;
      {pointer_high_bit, pointer_low_bit} = 2'h0;
      data_write = 1'b0;
      write_data = 16'h0000;
   end
   // one-cycle load, then an idle edge so a following write sees the new pointer
   task automatic set_ptr(input logic [1:0] p);
      @(posedge link_clock);
      #1;
      {pointer_high_bit, pointer_low_bit} = p;
      pointer_load = 1'b1;
      @(posedge link_clock);
      #1;
      pointer_load = 1'b0;
      {pointer_high_bit, pointer_low_bit} = ~p; // released lines do not keep last value
      @(posedge link_clock);
   endtask
   // writes spaced by ten link cycles so the crossing never merges two
   task automatic wr(input logic [1:0] p, input logic [15:0] d);
      set_ptr(p);
      #1;
      data_write = 1'b1;
      write_data = d;
      @(posedge link_clock);
      #1;
      data_write = 1'b0;
      write_data = ~d;
      repeat (10) @(posedge link_clock);
   endtask
   task automatic rd(input logic [1:0] p, output logic [15:0] d);
      set_ptr(p);
      repeat (2) @(posedge link_clock);
      #1;
      d = read_data;
   endtask
endmodule

// *** verilog/tsr_cdc_word.sv ***
// word crossing by toggle handshake, last loaded word wins
// assumes src_data is stable in the cycle src_load is high
`timescale 1ns/10ps
module tsr_cdc_word #(
   parameter int W = 18
) (
   input wire logic src_clock,
   input wire logic src_rst_n,
   input wire logic src_load,
   input wire logic [W-1:0] src_data,
   input wire logic dst_clock,
   input wire logic dst_rst_n,
   output logic dst_valid,
   output logic [W-1:0] dst_data
);
   typedef struct packed {
      logic req;
      logic ack_s1;
      logic ack_s2;
      logic pending;
      logic [W-1:0] latest;
      logic [W-1:0] hold;
   } tsr_src_type;
   typedef struct packed {
      logic req_s1;
      logic req_s2;
      logic req_s3;
      logic valid;
      logic [W-1:0] data;
   } tsr_dst_type;
   tsr_src_type s, next_s;
   tsr_dst_type d, next_d;

   // ***************************************************
   // source side
   // ***************************************************
   // hold only changes once the previous word was taken
   always_comb begin
      next_s = s;
      next_s.ack_s1 = d.req_s3;
      next_s.ack_s2 = s.ack_s1;
      if (src_load) begin
         next_s.latest = src_data;
         next_s.pending = 1'b1;
      end
      if (s.pending && (s.req == s.ack_s2)) begin
         next_s.hold = s.latest;
         next_s.req = ~s.req;
         next_s.pending = src_load;
      end
   end

   always_ff @(posedge src_clock or negedge src_rst_n) begin
      if (!src_rst_n) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   // ***************************************************
   // destination side
   // ***************************************************
   // hold is sampled only after req passed two flops
   always_comb begin
      next_d = d;
      next_d.req_s1 = s.req;
      next_d.req_s2 = d.req_s1;
      next_d.req_s3 = d.req_s2;
      next_d.valid = d.req_s2 != d.req_s3;
      if (d.req_s2 != d.req_s3) begin
         next_d.data = s.hold;
      end
   end

   always_ff @(posedge dst_clock or negedge dst_rst_n) begin
      if (!dst_rst_n) begin
         d <= '0;
      end else begin
         d <= next_d;
      end
   end

   assign dst_valid = d.valid;
   assign dst_data = d.data;
endmodule

// *** verilog/tsr_conv_timer.sv ***
// conversion interval timer, length doubles with each extra result bit
// assumes start and stop come from logic on the same clock
`timescale 1ns/10ps
module tsr_conv_timer #(
   parameter logic [24:0] BASE_CYCLES = tsr_pkg::CONV9_CYCLES
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic start,
   input wire logic stop,
   input wire logic [1:0] res,
   output logic done
);
   typedef struct packed {
      logic [24:0] count;
      logic running;
      logic done;
   } tsr_timer_type;
   tsr_timer_type s, next_s;

   // ***************************************************
   // countdown
   // ***************************************************
   // stop wins over start so an abort never leaves a stray done
   always_comb begin
      next_s = s;
      next_s.done = 1'b0;
      if (stop) begin
         next_s.running = 1'b0;
      end else if (start) begin
         next_s.count = (BASE_CYCLES << res) - 25'h1;
         next_s.running = 1'b1;
      end else if (s.running) begin
         if (s.count == 25'h0) begin
            next_s.running = 1'b0;
            next_s.done = 1'b1;
         end else begin
            next_s.count = s.count - 25'h1;
         end
      end
   end

   // state register
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign done = s.done;
endmodule

// *** verilog/tsr_pkg.sv ***
// constants, types and register map of the temperature result and setup block
// assumes a 100 MHz system clock and a register link on its own clock
// Function
// (RL1) 16-bit read-only ambient result, 9-12 bits
// (RL2) ambient result is two's complement
// (RL3) result refreshed once per conversion
// (RL4) reads return last completed result only
// (RL5) result scaled at one sixteenth degree
// (RL6) sign bit 15, low nibble always zero
// (RL7) unused fraction bits cleared at coarse resolution
// (RL8) 8-bit setup register, all zero at reset
// (RL9) setup bit 7 requests single conversion
// (RL10) setup bits 6:5 select resolution
// (RL11) setup bits 4:3 select fault queue depth
// (RL12) setup bit 2 selects alert polarity
// (RL13) setup bit 1 selects interrupt or comparator
// (RL14) setup bit 0 enters shutdown
// (RL15) 2-bit pointer selects the register
// (RL16) limits keep nine upper bits only
// (RL17) single conversion done clears setup bit 7
// (RL18) resolution change applies from next conversion
package tsr_pkg;
   // ***************************************************
   // register pointer codes
   // ***************************************************
   localparam logic [1:0] PTR_AMBIENT = 2'h0;
   localparam logic [1:0] PTR_SETUP = 2'h1;
   localparam logic [1:0] PTR_LOWER = 2'h2;
   localparam logic [1:0] PTR_UPPER = 2'h3;
   // ***************************************************
   // setup and limit field positions
   // ***************************************************
   localparam int CFG_ONESHOT = 7;
   localparam int CFG_RES_LSB = 5;
   localparam int CFG_FQ_LSB = 3;
   localparam int CFG_POLARITY = 2;
   localparam int CFG_INT_MODE = 1;
   localparam int CFG_SHUTDOWN = 0;
   localparam int LIMIT_LSB = 7;
   // ***************************************************
   // values after reset
   // ***************************************************
   localparam logic [15:0] AMBIENT_RESET = 16'h0000;
   localparam logic [7:0] SETUP_RESET = 8'h00;
   localparam logic [8:0] LOWER_RESET = 9'h096;
   localparam logic [8:0] UPPER_RESET = 9'h0a0;
   // ***************************************************
   // timing: 9-bit conversion time, doubled per extra bit
   // ***************************************************
   localparam int CLOCK_KHZ = 100000;
   localparam int CONV9_TIME_MS = 30;
   localparam logic [24:0] CONV9_CYCLES = 25'(CONV9_TIME_MS * CLOCK_KHZ);
   // ***************************************************
   // converter states
   // ***************************************************
   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_CONV = 2'b10
   } tsr_state_type;
endpackage

// *** verilog/tsr_top.sv ***
// ambient result, setup and limit registers with a link-clocked access port
// assumes a protocol engine on link_clock drives pointer and write strobes
// and an analog converter presents a settled 12-bit code at adc_code
`timescale 1ns/10ps
module tsr_top #(
   parameter logic [24:0] CONV9_CYCLES = tsr_pkg::CONV9_CYCLES
) (
   input wire logic clock,
   input wire logic arst_n,
   input wire logic link_clock,
   input wire logic pointer_load,
   input wire logic pointer_high_bit,
   input wire logic pointer_low_bit,
   input wire logic data_write,
   input wire logic [15:0] write_data,
   output logic [15:0] read_data,
   input wire logic [11:0] adc_code,
   output logic conv_start,
   output logic converting,
   output logic [15:0] ambient_temperature,
   output logic [7:0] sensor_setup,
   output logic [8:0] lower_release_limit,
   output logic [8:0] upper_trip_limit,
   output logic [2:0] fault_queue_count
);
   // ***************************************************
   // helpers
   // ***************************************************
   // keep 9 + res top bits of the code, low nibble zero
   function automatic logic [15:0] ambient_word(input logic [11:0] code, input logic [1:0] res);
      logic [11:0] keep;
      keep = 12'hfff << (2'h3 - res);
      return {code & keep, 4'h0};
   endfunction

   // a 9-bit limit sits in the top of a 16-bit word
   function automatic logic [15:0] limit_word(input logic [8:0] lim);
      return {lim, 7'h00};
   endfunction

   // queue depth code to number of consecutive faults
   function automatic logic [2:0] fault_depth(input logic [1:0] code);
      logic [2:0] n;
      n = 3'h1;
      unique case (code)
         2'h0: n = 3'h1;
         2'h1: n = 3'h2;
         2'h2: n = 3'h4;
         2'h3: n = 3'h6;
      endcase
      return n;
   endfunction

   // ***************************************************
   // reset release, one pair of flops per domain
   // ***************************************************
   logic [1:0] rst_pipe;
   logic [1:0] link_rst_pipe;
   logic rst_n;
   logic link_rst_n;

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         rst_pipe <= 2'h0;
      end else begin
         rst_pipe <= {rst_pipe[0], 1'b1};
      end
   end

   always_ff @(posedge link_clock or negedge arst_n) begin
      if (!arst_n) begin
         link_rst_pipe <= 2'h0;
      end else begin
         link_rst_pipe <= {link_rst_pipe[0], 1'b1};
      end
   end

   assign rst_n = rst_pipe[1];
   assign link_rst_n = link_rst_pipe[1];

   // ***************************************************
   // state of both domains
   // ***************************************************
   typedef struct packed {
      tsr_pkg::tsr_state_type state;
      logic [1:0] conv_res;
      logic oneshot_run;
      logic start;
      logic [15:0] ambient;
      logic [7:0] setup;
      logic [8:0] lower;
      logic [8:0] upper;
      logic [2:0] fq;
   } tsr_sys_type;
   typedef struct packed {
      logic [1:0] pointer;
      logic [15:0] rdata;
   } tsr_link_type;
   tsr_sys_type s, next_s;
   tsr_link_type k, next_k;

   logic wr_valid;
   logic [17:0] wr_word;
   logic [41:0] snap_word;
   logic [41:0] mirror;
   logic t_done;
   logic t_stop;
   logic setup_wr;
   logic [15:0] amb_calc;

   // ***************************************************
   // crossings
   // ***************************************************
   // writes go to the system clock, pointer travels with the data
   tsr_cdc_word #(.W(18)) u_write_cdc (
      .src_clock(link_clock),
      .src_rst_n(link_rst_n),
      .src_load(data_write),
      .src_data({k.pointer, write_data}),
      .dst_clock(clock),
      .dst_rst_n(rst_n),
      .dst_valid(wr_valid),
      .dst_data(wr_word)
   );

   // whole register image crosses as one word so reads never tear
   assign snap_word = {s.ambient, s.setup, s.lower, s.upper};
   tsr_cdc_word #(.W(42)) u_snap_cdc (
      .src_clock(clock),
      .src_rst_n(rst_n),
      .src_load(1'b1),
      .src_data(snap_word),
      .dst_clock(link_clock),
      .dst_rst_n(link_rst_n),
      .dst_valid(),
      .dst_data(mirror)
   ); // RL4

   tsr_conv_timer #(.BASE_CYCLES(CONV9_CYCLES)) u_timer (
      .clock(clock),
      .rst_n(rst_n),
      .start(s.start),
      .stop(t_stop),
      .res(s.conv_res),
      .done(t_done)
   ); // RL3

   // ***************************************************
   // system side registers and converter sequencing
   // ***************************************************
   assign setup_wr = wr_valid && (wr_word[17:16] == tsr_pkg::PTR_SETUP);
   assign amb_calc = ambient_word(adc_code, s.conv_res); // RL7
   // a running continuous conversion is dropped once shutdown is set
   assign t_stop = (s.state == tsr_pkg::ST_CONV) && !s.oneshot_run && !t_done && s.setup[tsr_pkg::CFG_SHUTDOWN];

   always_comb begin
      next_s = s;
      next_s.start = 1'b0;
      // register writes; the ambient word is read-only
      if (wr_valid) begin
         unique case (wr_word[17:16])
            tsr_pkg::PTR_AMBIENT: next_s.ambient = s.ambient; // RL1
            tsr_pkg::PTR_SETUP: next_s.setup = wr_word[7:0]; // RL8
            tsr_pkg::PTR_LOWER: next_s.lower = wr_word[15:tsr_pkg::LIMIT_LSB]; // RL16
            tsr_pkg::PTR_UPPER: next_s.upper = wr_word[15:tsr_pkg::LIMIT_LSB]; // RL16
         endcase
      end
      // finished conversion loads the result in one step
      if (t_done) begin
         next_s.ambient = amb_calc; // RL2
         // a write setting the request in this cycle keeps it
         if (s.oneshot_run && !(setup_wr && wr_word[tsr_pkg::CFG_ONESHOT])) begin
            next_s.setup[tsr_pkg::CFG_ONESHOT] = 1'b0; // RL17
         end
      end
      unique case (s.state)
         tsr_pkg::ST_IDLE: begin
            // shutdown alone idles, shutdown plus request runs once
            if (!s.setup[tsr_pkg::CFG_SHUTDOWN] || s.setup[tsr_pkg::CFG_ONESHOT]) begin // RL14
               next_s.start = 1'b1;
               next_s.state = tsr_pkg::ST_CONV;
               next_s.conv_res = s.setup[tsr_pkg::CFG_RES_LSB +: 2]; // RL10
               next_s.oneshot_run = s.setup[tsr_pkg::CFG_SHUTDOWN]; // RL9
            end
         end
         tsr_pkg::ST_CONV: begin
            if (t_done) begin
               if (!s.setup[tsr_pkg::CFG_SHUTDOWN]) begin
                  // back to back in continuous mode, new resolution taken here
                  next_s.start = 1'b1;
                  next_s.conv_res = s.setup[tsr_pkg::CFG_RES_LSB +: 2]; // RL18
                  next_s.oneshot_run = 1'b0;
               end else begin
                  next_s.state = tsr_pkg::ST_IDLE;
               end
            end else if (t_stop) begin
               next_s.state = tsr_pkg::ST_IDLE; // RL14
            end else if (!s.setup[tsr_pkg::CFG_SHUTDOWN]) begin
               // leaving shutdown mid single run turns it continuous
               next_s.oneshot_run = 1'b0;
            end
         end
         default: begin
            next_s.state = tsr_pkg::ST_IDLE;
         end
      endcase
      next_s.fq = fault_depth(next_s.setup[tsr_pkg::CFG_FQ_LSB +: 2]); // RL11
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         s.state <= tsr_pkg::ST_IDLE;
         s.conv_res <= 2'h0;
         s.oneshot_run <= 1'b0;
         s.start <= 1'b0;
         s.ambient <= tsr_pkg::AMBIENT_RESET;
         s.setup <= tsr_pkg::SETUP_RESET; // RL8
         s.lower <= tsr_pkg::LOWER_RESET;
         s.upper <= tsr_pkg::UPPER_RESET;
         s.fq <= 3'h1;
      end else begin
         s <= next_s;
      end
   end

   // ***************************************************
   // link side pointer and read port
   // ***************************************************
   // read data follows the pointer one link cycle later
   always_comb begin
      next_k = k;
      if (pointer_load) begin
         next_k.pointer = {pointer_high_bit, pointer_low_bit}; // RL15
      end
      unique case (k.pointer)
         tsr_pkg::PTR_AMBIENT: next_k.rdata = mirror[41:26]; // RL6
         tsr_pkg::PTR_SETUP: next_k.rdata = {8'h00, mirror[25:18]};
         tsr_pkg::PTR_LOWER: next_k.rdata = limit_word(mirror[17:9]);
         tsr_pkg::PTR_UPPER: next_k.rdata = limit_word(mirror[8:0]);
      endcase
   end

   always_ff @(posedge link_clock or negedge link_rst_n) begin
      if (!link_rst_n) begin
         k <= '0;
      end else begin
         k <= next_k;
      end
   end

   // polarity and mode bits reach the alert logic through sensor_setup
   assign read_data = k.rdata;
   assign conv_start = s.start;
   assign converting = s.state == tsr_pkg::ST_CONV;
   assign ambient_temperature = s.ambient; // RL5
   assign sensor_setup = s.setup; // RL12 RL13
   assign lower_release_limit = s.lower;
   assign upper_trip_limit = s.upper;
   assign fault_queue_count = s.fq;

   // ***************************************************
   // assertions
   // ***************************************************
   property p_low_nibble;
      @(posedge clock) disable iff (!rst_n) ambient_temperature[3:0] == 4'h0;
   endproperty
   a_low_nibble: assert property (p_low_nibble) else $error("ambient low nibble not zero"); // RL6

   property p_coarse_zero;
      @(posedge clock) disable iff (!rst_n) t_done && (s.conv_res == 2'h0) |=> ambient_temperature[6:4] == 3'h0;
   endproperty
   a_coarse_zero: assert property (p_coarse_zero) else $error("9-bit result has fraction bits"); // RL7

   property p_hold_between;
      @(posedge clock) disable iff (!rst_n) !t_done |=> $stable(ambient_temperature);
   endproperty
   a_hold_between: assert property (p_hold_between) else $error("ambient changed without conversion"); // RL4

   property p_load_code;
      @(posedge clock) disable iff (!rst_n) t_done |=> ambient_temperature == $past(amb_calc);
   endproperty
   a_load_code: assert property (p_load_code) else $error("ambient not loaded from code"); // RL2

   property p_oneshot_clear;
      @(posedge clock) disable iff (!rst_n) t_done && s.oneshot_run && !setup_wr |=> !sensor_setup[7] ##1 !converting;
   endproperty
   a_oneshot_clear: assert property (p_oneshot_clear) else $error("single request not cleared"); // RL17

   property p_depth_six;
      @(posedge clock) disable iff (!rst_n) sensor_setup[4:3] == 2'h3 |-> fault_queue_count == 3'h6;
   endproperty
   a_depth_six: assert property (p_depth_six) else $error("fault depth wrong"); // RL11

   property p_shutdown_idle;
      @(posedge clock) disable iff (!rst_n) !converting && sensor_setup[0] && !sensor_setup[7] && !wr_valid
         |=> !conv_start && !converting;
   endproperty
   a_shutdown_idle: assert property (p_shutdown_idle) else $error("conversion started in shutdown"); // RL14

   property p_restart;
      @(posedge clock) disable iff (!rst_n) converting && t_done && !sensor_setup[0] |=> conv_start && converting;
   endproperty
   a_restart: assert property (p_restart) else $error("continuous conversion not restarted"); // RL3

   property p_res_hold;
      @(posedge clock) disable iff (!rst_n) converting && !t_done |=> $stable(s.conv_res);
   endproperty
   a_res_hold: assert property (p_res_hold) else $error("resolution changed mid conversion"); // RL18

   property p_limit_write;
      @(posedge clock) disable iff (!rst_n) wr_valid && (wr_word[17:16] == tsr_pkg::PTR_LOWER)
         |=> lower_release_limit == $past(wr_word[15:7]);
   endproperty
   a_limit_write: assert property (p_limit_write) else $error("lower limit not written"); // RL16

   property p_read_ambient;
      @(posedge link_clock) disable iff (!link_rst_n) k.pointer == tsr_pkg::PTR_AMBIENT |=> read_data == $past(mirror[41:26]);
   endproperty
   a_read_ambient: assert property (p_read_ambient) else $error("pointer did not select ambient"); // RL15

   property p_setup_write;
      @(posedge clock) disable iff (!rst_n) setup_wr && !t_done |=> sensor_setup == $past(wr_word[7:0]);
   endproperty
   a_setup_write: assert property (p_setup_write) else $error("setup register not written"); // RL8

   property p_single_start;
      @(posedge clock) disable iff (!rst_n) !converting && sensor_setup[0] && sensor_setup[7]
         |=> conv_start && converting && (s.conv_res == $past(sensor_setup[6:5]));
   endproperty
   a_single_start: assert property (p_single_start) else $error("single conversion not started"); // RL9 RL10

   property p_continuous_start;
      @(posedge clock) disable iff (!rst_n) !converting && !sensor_setup[0] |=> conv_start && converting;
   endproperty
   a_continuous_start: assert property (p_continuous_start) else $error("continuous run not started"); // RL14

   property p_upper_write;
      @(posedge clock) disable iff (!rst_n) wr_valid && (wr_word[17:16] == tsr_pkg::PTR_UPPER)
         |=> upper_trip_limit == $past(wr_word[15:7]);
   endproperty
   a_upper_write: assert property (p_upper_write) else $error("upper limit not written"); // RL16

   c_oneshot: cover property (@(posedge clock) disable iff (!rst_n) t_done && s.oneshot_run);
   c_restart: cover property (@(posedge clock) disable iff (!rst_n) t_done && !sensor_setup[0] ##1 conv_start);
   c_abort: cover property (@(posedge clock) disable iff (!rst_n) t_stop);
   c_setup_write: cover property (@(posedge clock) disable iff (!rst_n) setup_wr);
endmodule
